// file: verilog/api_framer_regs.svh
`ifndef API_FRAMER_REGS_SVH
`define API_FRAMER_REGS_SVH

// Frame layout bytes and offsets
`define START_DELIMITER 8'h7E
`define TYPE_TX_STATUS 8'h89
`define TYPE_RX_LONG 8'h80
`define OFS_LENGTH 4'h1
`define OFS_TYPE 4'h3
`define OFS_FRAME_ID 4'h4
`define OFS_DELIVERY 4'h5
`define OFS_SOURCE 4'h4
`define OFS_SIGNAL 4'hC
`define OFS_OPTIONS 4'hD
`define OFS_PAYLOAD 4'hE
`define CHECKSUM_BASE 8'hFF

// Lengths between length field and checksum
`define STATUS_LENGTH 16'h0003
`define RX_FIXED_LENGTH 16'h000B

// Configuration values
`define OUTPUT_FORMAT_LEGACY 8'h02
`define LONG_ADDRESS_MARK 16'hFFFE
`define ESCAPE_RAW 8'h01

// Receive option bits
`define OPT_BROADCAST_BIT 1
`define OPT_ALL_PAN_BIT 2

// Delivery status codes kept by this radio variant
`define DS_SUCCESS 8'h00
`define DS_NO_ACK 8'h01
`define DS_CCA_FAIL 8'h02
`define DS_INDIRECT 8'h03
`define DS_TRX_FAIL 8'h04
`define DS_NET_ACK 8'h21
`define DS_NOT_JOINED 8'h22
`define DS_INTERNAL 8'h31
`define DS_RESOURCE 8'h32
`define DS_TOO_LONG 8'h74

// Payload FIFO
`define FIFO_DEPTH 16
`define FIFO_WIDTH 9

`endif

// file: verilog/api_framer_pkg.sv
`default_nettype none
package api_framer_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DELIM = 3'b001,
    ST_LEN_HI = 3'b010,
    ST_LEN_LO = 3'b011,
    ST_HEADER = 3'b100,
    ST_PAYLOAD = 3'b101,
    ST_CHECKSUM = 3'b110
  } frame_state_type;

  typedef enum logic [0:0] {
    KIND_STATUS = 1'b0,
    KIND_RX = 1'b1
  } frame_kind_type;

endpackage : api_framer_pkg
`default_nettype wire

// file: verilog/byte_stream_if.sv
`default_nettype none
interface byte_stream_if #(parameter int WIDTH = 9);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : byte_stream_if
`default_nettype wire

// file: verilog/payload_fifo.sv
`default_nettype none
module payload_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Filling side
  byte_stream_if.sink fill,
  // Draining side
  byte_stream_if.source drain
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign fill.ready = (count != DEPTH[AW:0]);
  assign drain.valid = (count != '0);
  assign drain.data = store[rd_ptr];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      store[wr_ptr] <= fill.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : payload_fifo
`default_nettype wire

// file: verilog/api_status_rx_framer.sv
`include "api_framer_regs.svh"
`default_nettype none
module api_status_rx_framer (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration settings
  input wire logic [7:0] api_output_format,
  input wire logic [7:0] api_escape_setting,
  // Transmit completion event
  input wire logic tx_done_valid,
  output logic tx_done_ready,
  input wire logic [7:0] tx_frame_id,
  input wire logic [7:0] tx_delivery,
  input wire logic tx_broadcast,
  // Received packet header
  input wire logic rx_hdr_valid,
  output logic rx_hdr_ready,
  input wire logic [15:0] source_short_address,
  input wire logic [63:0] rx_source_long,
  input wire logic [7:0] rx_signal_dbm,
  input wire logic rx_was_broadcast,
  input wire logic rx_all_pan,
  input wire logic [15:0] rx_payload_length,
  // Received payload bytes, last flag with final byte
  input wire logic rx_data_valid,
  output logic rx_data_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_data_last,
  // Serial API output bytes
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_last,
  // Status
  output logic busy,
  output logic rx_dropped,
  output logic unescaped_mode
);

  api_framer_pkg::frame_state_type state;
  api_framer_pkg::frame_kind_type kind;
  logic [15:0] length;
  logic [7:0] header [11];
  logic [3:0] hdr_count;
  logic [3:0] hdr_index;
  logic [15:0] pay_count;
  logic [7:0] sum;
  logic drop_payload;
  logic rx_accept;
  logic tx_accept;
  logic rx_wanted;
  logic slot_free;
  logic [7:0] next_byte;
  logic next_last;
  logic advance;

  byte_stream_if #(.WIDTH(`FIFO_WIDTH)) pay_in ();
  byte_stream_if #(.WIDTH(`FIFO_WIDTH)) pay_out ();

  // Broadcast reads as success; otherwise keep only this radio's delivery codes, anything else reads as internal error
  function automatic logic [7:0] filter_delivery(input logic [7:0] code, input logic bcast);
    logic [7:0] result;
    result = `DS_INTERNAL;
    if (bcast)
    begin
      result = `DS_SUCCESS;
    end
    else
    begin
      case (code)
        `DS_SUCCESS, `DS_NO_ACK, `DS_CCA_FAIL, `DS_INDIRECT, `DS_TRX_FAIL: result = code;
        `DS_NET_ACK, `DS_NOT_JOINED, `DS_INTERNAL, `DS_RESOURCE,
        `DS_TOO_LONG: result = code;
        default: result = `DS_INTERNAL;
      endcase
    end
    return result;
  endfunction : filter_delivery

  // Payload buffer; its fill ready stalls the payload source
  payload_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .fill(pay_in),
    .drain(pay_out)
  );

  // Payload enters the FIFO only for a frame being built; dropped ones are sunk
  assign pay_in.valid = rx_data_valid && (state != api_framer_pkg::ST_IDLE)
    && (kind == api_framer_pkg::KIND_RX) && !drop_payload;
  assign pay_in.data = {rx_data_last, rx_data};
  assign rx_data_ready = drop_payload ? 1'b1 : (pay_in.ready && (state !=
    api_framer_pkg::ST_IDLE) && (kind == api_framer_pkg::KIND_RX));

  // Receive frame only under legacy format and long sender
  assign rx_wanted = (api_output_format == `OUTPUT_FORMAT_LEGACY)
    && (source_short_address == `LONG_ADDRESS_MARK);
  // A new frame waits until the previous checksum has left
  assign slot_free = (state == api_framer_pkg::ST_IDLE) && !out_valid && !drop_payload;
  // Status events take priority; a zero identifier is consumed silently
  assign tx_accept = slot_free && tx_done_valid;
  assign rx_accept = slot_free && !tx_done_valid && rx_hdr_valid;
  assign advance = !out_valid || out_ready;

  // Handshake readies for the event inputs
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tx_done_ready <= 1'b0;
      rx_hdr_ready <= 1'b0;
    end
    else
    begin
      tx_done_ready <= 1'b0;
      rx_hdr_ready <= 1'b0;
      if (tx_accept && !tx_done_ready)
      begin
        tx_done_ready <= 1'b1;
      end
      if (rx_accept && !rx_hdr_ready)
      begin
        rx_hdr_ready <= 1'b1;
      end
    end
  end

  // Capture frame content when an event is taken
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      kind <= api_framer_pkg::KIND_STATUS;
      length <= 16'h0000;
      hdr_count <= 4'h0;
      drop_payload <= 1'b0;
      rx_dropped <= 1'b0;
      for (int i = 0; i < 11; i++)
      begin
        header[i] <= 8'h00;
      end
    end
    else
    begin
      rx_dropped <= 1'b0;
      if (drop_payload && rx_data_valid && rx_data_last)
      begin
        drop_payload <= 1'b0;
      end
      if (tx_done_ready && tx_frame_id != 8'h00)
      begin
        kind <= api_framer_pkg::KIND_STATUS;
        length <= `STATUS_LENGTH;
        hdr_count <= 4'h3;
        header[0] <= `TYPE_TX_STATUS;
        header[1] <= tx_frame_id;
        header[2] <= filter_delivery(tx_delivery, tx_broadcast);
      end
      else if (rx_hdr_ready && rx_wanted)
      begin
        kind <= api_framer_pkg::KIND_RX;
        length <= 16'(`RX_FIXED_LENGTH + rx_payload_length);
        hdr_count <= 4'hB;
        header[0] <= `TYPE_RX_LONG;
        for (int i = 0; i < 8; i++)
        begin
          header[1 + i] <= rx_source_long[63 - 8 * i -: 8];
        end
        header[9] <= rx_signal_dbm;
        header[10] <= {5'b0_0000, rx_all_pan, rx_was_broadcast, 1'b0};
      end
      else if (rx_hdr_ready && rx_payload_length != 16'h0000)
      begin
        drop_payload <= 1'b1;
        rx_dropped <= 1'b1;
      end
    end
  end

  // Frame sequencer
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state <= api_framer_pkg::ST_IDLE;
      hdr_index <= 4'h0;
      pay_count <= 16'h0000;
    end
    else
    begin
      case (state)
        api_framer_pkg::ST_IDLE:
        begin
          if ((tx_done_ready && tx_frame_id != 8'h00) || (rx_hdr_ready && rx_wanted))
          begin
            state <= api_framer_pkg::ST_DELIM;
          end
        end
        api_framer_pkg::ST_DELIM:
        begin
          if (advance)
          begin
            state <= api_framer_pkg::ST_LEN_HI;
          end
        end
        api_framer_pkg::ST_LEN_HI:
        begin
          if (advance)
          begin
            state <= api_framer_pkg::ST_LEN_LO;
          end
        end
        api_framer_pkg::ST_LEN_LO:
        begin
          if (advance)
          begin
            state <= api_framer_pkg::ST_HEADER;
            hdr_index <= 4'h0;
          end
        end
        api_framer_pkg::ST_HEADER:
        begin
          if (advance)
          begin
            hdr_index <= hdr_index + 4'h1;
            if (hdr_index == hdr_count - 4'h1)
            begin
              pay_count <= length - ((kind == api_framer_pkg::KIND_RX) ?
                `RX_FIXED_LENGTH : `STATUS_LENGTH);
              state <= (kind == api_framer_pkg::KIND_RX && length != `RX_FIXED_LENGTH) ?
                api_framer_pkg::ST_PAYLOAD : api_framer_pkg::ST_CHECKSUM;
            end
          end
        end
        api_framer_pkg::ST_PAYLOAD:
        begin
          if (advance && pay_out.valid)
          begin
            pay_count <= pay_count - 16'h0001;
            if (pay_count == 16'h0001)
            begin
              state <= api_framer_pkg::ST_CHECKSUM;
            end
          end
        end
        api_framer_pkg::ST_CHECKSUM:
        begin
          if (advance)
          begin
            state <= api_framer_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state <= api_framer_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Payload leaves the FIFO as it is sent; length field bounds it, not the last flag
  assign pay_out.ready = (state == api_framer_pkg::ST_PAYLOAD) && advance;

  // Byte to present in the current state
  always_comb
  begin
    next_byte = 8'h00;
    next_last = 1'b0;
    case (state)
      api_framer_pkg::ST_DELIM: next_byte = `START_DELIMITER;
      api_framer_pkg::ST_LEN_HI: next_byte = length[15:8];
      api_framer_pkg::ST_LEN_LO: next_byte = length[7:0];
      api_framer_pkg::ST_HEADER: next_byte = header[hdr_index];
      api_framer_pkg::ST_PAYLOAD: next_byte = pay_out.data[7:0];
      api_framer_pkg::ST_CHECKSUM:
      begin
        next_byte = `CHECKSUM_BASE - sum;
        next_last = 1'b1;
      end
      default: next_byte = 8'h00;
    endcase
  end

  // Output register; bytes go raw, no escape substitution in this block
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      out_valid <= 1'b0;
      out_data <= 8'h00;
      out_last <= 1'b0;
    end
    else if (advance)
    begin
      out_valid <= (state != api_framer_pkg::ST_IDLE) &&
        (state != api_framer_pkg::ST_PAYLOAD || pay_out.valid);
      out_data <= next_byte;
      out_last <= next_last;
    end
  end

  // Running sum from the type byte up to the last payload byte
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sum <= 8'h00;
    end
    else if (state == api_framer_pkg::ST_IDLE)
    begin
      sum <= 8'h00;
    end
    else if (advance && (state == api_framer_pkg::ST_HEADER ||
      (state == api_framer_pkg::ST_PAYLOAD && pay_out.valid)))
    begin
      sum <= sum + next_byte;
    end
  end

  // Status outputs
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      busy <= 1'b0;
      unescaped_mode <= 1'b0;
    end
    else
    begin
      busy <= (state != api_framer_pkg::ST_IDLE) || out_valid;
      unescaped_mode <= (api_escape_setting == `ESCAPE_RAW);
    end
  end

endmodule : api_status_rx_framer
`default_nettype wire

// file: verif/host_link_model.sv
`default_nettype none
module host_link_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Stall control from the bench
  input wire logic slow,
  // Serial API byte stream
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic [7:0] sum = 8'h00;
  logic ph = 1'b0;
  int frames = 0;
  int bad_sum = 0;
  int idx = 0;
  initial out_ready = 1'b0;
  // Half-rate ready when stalling, so the framer must hold each byte
  always @(negedge clk)
  begin
    ph <= ~ph;
    out_ready <= !slow || ph;
  end
  // Bytes arrive raw, the checksum is verified from offset 3 on
  always @(posedge clk)
  begin
    if (resetn && out_valid && out_ready)
    begin
      got.push_back(out_data);
      if (out_last)
      begin
        if (out_data !== 8'hFF - sum) bad_sum++;
        frames++;
        idx = 0;
        sum = 8'h00;
      end
      else
      begin
        if (idx >= 3) sum = sum + out_data;
        idx++;
      end
    end
  end
endmodule : host_link_model
`default_nettype wire

// file: verif/api_status_rx_framer_assertions.sv
`default_nettype none
module api_status_rx_framer_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Events and settings
  input wire logic tx_done_ready,
  input wire logic [7:0] tx_frame_id,
  input wire logic tx_broadcast,
  input wire logic rx_hdr_ready,
  input wire logic [7:0] api_output_format,
  input wire logic [15:0] source_short_address,
  input wire logic [7:0] api_escape_setting,
  // Output stream
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic unescaped_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] idx;
  logic [15:0] len;
  logic [7:0] sum;
  logic [7:0] id_q;
  logic st;
  logic bc_q;
  logic ok_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Byte position, length field and running sum of the frame on the wire
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      idx <= 16'h0000;
      sum <= 8'h00;
      len <= 16'h0000;
      st <= 1'b0;
    end
    else if (out_valid && out_ready)
    begin
      idx <= out_last ? 16'h0000 : idx + 16'h0001;
      sum <= out_last ? 8'h00 : ((idx >= 16'h0003) ? sum + out_data : sum);
      if (idx == 16'h0001) len[15:8] <= out_data;
      if (idx == 16'h0002) len[7:0] <= out_data;
      if (idx == 16'h0003) st <= (out_data == 8'h89);
    end
  end
  // Request fields kept from the edge where each event is taken
  always_ff @(posedge clk)
  begin
    if (tx_done_ready)
    begin
      id_q <= tx_frame_id;
      bc_q <= tx_broadcast;
    end
    if (rx_hdr_ready) ok_q <= (api_output_format == 8'h02 && source_short_address == 16'hFFFE);
  end
  sequence s_delim;
    out_valid && out_data == 8'h7E;
  endsequence
  a_frame_start: assert property (out_valid && idx == 16'h0000 |-> s_delim)
    else $error("frame does not open with the delimiter");
  a_length_field: assert property (out_valid && out_last |-> idx - 16'h0003 == len)
    else $error("length field disagrees with byte count");
  a_check_sum: assert property (out_valid && out_last |-> out_data == 8'hFF - sum)
    else $error("checksum byte wrong");
  a_hold_byte: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data) && $stable(out_last))
    else $error("output byte changed before acceptance");
  a_id_echo: assert property (out_valid && idx == 16'h0004 && st |-> out_data == id_q)
    else $error("status frame id does not match request");
  a_code_subset: assert property (out_valid && idx == 16'h0005 && st |-> out_data inside
    {8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h21, 8'h22, 8'h31, 8'h32, 8'h74})
    else $error("delivery code outside the subset");
  a_bcast_ok: assert property (out_valid && idx == 16'h0005 && st && bc_q |-> out_data == 8'h00)
    else $error("broadcast status not success");
  a_rx_gate: assert property (out_valid && idx == 16'h0003 && out_data == 8'h80 |-> ok_q)
    else $error("receive frame without legacy format and long sender");
  // Ready pulse is seen on the capture edge, delimiter shows two edges after that
  a_tx_answer: assert property (tx_done_ready && tx_frame_id != 8'h00 |-> ##2 s_delim)
    else $error("status frame did not start after event");
  a_zero_quiet: assert property (tx_done_ready && tx_frame_id == 8'h00 |=> !out_valid [*2])
    else $error("frame sent for zero id");
  a_raw_mode: assert property ($past(resetn) |->
    unescaped_mode == ($past(api_escape_setting) == 8'h01))
    else $error("raw mode flag wrong");
endmodule : api_status_rx_framer_checker
bind api_status_rx_framer api_status_rx_framer_checker i_chk (.clk, .resetn, .tx_done_ready,
  .tx_frame_id, .tx_broadcast, .rx_hdr_ready, .api_output_format, .source_short_address,
  .api_escape_setting, .out_valid, .out_ready, .out_data, .out_last, .unescaped_mode);
`default_nettype wire

// file: verif/tb_api_status_rx_framer.sv
`default_nettype none
module tb_api_status_rx_framer;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] api_output_format = 8'h02;
  logic [7:0] api_escape_setting = 8'h01;
  logic tx_done_valid = 1'b0;
  logic [7:0] tx_frame_id = 8'h00;
  logic [7:0] tx_delivery = 8'h00;
  logic tx_broadcast = 1'b0;
  logic rx_hdr_valid = 1'b0;
  logic [15:0] source_short_address = 16'hFFFE;
  logic [63:0] rx_source_long = 64'h0011_2233_4455_6677;
  logic [7:0] rx_signal_dbm = 8'h5E;
  logic rx_was_broadcast = 1'b0;
  logic rx_all_pan = 1'b0;
  logic [15:0] rx_payload_length = 16'h0000;
  logic rx_data_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic rx_data_last = 1'b0;
  logic slow = 1'b0;
  wire logic tx_done_ready, rx_hdr_ready, rx_data_ready, out_valid, out_ready, out_last;
  wire logic busy, rx_dropped, unescaped_mode;
  wire logic [7:0] out_data;
  int err_total = 0;
  int n_compared = 0;
  int nfr = 0;
  int drops = 0;
  int stalls = 0;
  int cyc = 0;
  logic [7:0] exp[$];
  logic [7:0] codes[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h21, 8'h22, 8'h31, 8'h32, 8'h74};
  api_status_rx_framer i_dut (.clk, .resetn, .api_output_format, .api_escape_setting,
    .tx_done_valid, .tx_done_ready, .tx_frame_id, .tx_delivery, .tx_broadcast, .rx_hdr_valid,
    .rx_hdr_ready, .source_short_address, .rx_source_long, .rx_signal_dbm, .rx_was_broadcast,
    .rx_all_pan, .rx_payload_length, .rx_data_valid, .rx_data_ready, .rx_data, .rx_data_last,
    .out_valid, .out_ready, .out_data, .out_last, .busy, .rx_dropped, .unescaped_mode);
  host_link_model i_host (.clk, .resetn, .slow, .out_valid, .out_data, .out_last, .out_ready);
  // Clock, hang guard and drop pulse counter
  initial forever #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_total++;
      $display("MISMATCH t=%0t run did not finish", $time);
      conclude();
    end
  end
  always @(posedge clk) if (rx_dropped === 1'b1) drops++;
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // Valid is held through the edge that samples the ready pulse
  task automatic take(input int sel);
    int t;
    t = 0;
    do
    begin
      @(negedge clk);
      t++;
    end
    while (((sel == 0) ? tx_done_ready : rx_hdr_ready) !== 1'b1 && t < 300);
    @(negedge clk);
  endtask : take
  task automatic send_tx(input logic [7:0] id, input logic [7:0] ds, input logic bc);
    @(negedge clk);
    tx_frame_id = id;
    tx_delivery = ds;
    tx_broadcast = bc;
    tx_done_valid = 1'b1;
    take(0);
    tx_done_valid = 1'b0;
  endtask : send_tx
  // Payload bytes wait while the buffer refuses them
  task automatic send_rx(input int n, input logic bc, input logic ap);
    int t;
    @(negedge clk);
    rx_payload_length = 16'(n);
    rx_was_broadcast = bc;
    rx_all_pan = ap;
    rx_hdr_valid = 1'b1;
    take(1);
    rx_hdr_valid = 1'b0;
    for (int j = 0; j < n; j++)
    begin
      rx_data = 8'h70 + j[7:0];
      rx_data_last = (j == n - 1);
      rx_data_valid = 1'b1;
      #1;
      t = 0;
      while (rx_data_ready !== 1'b1 && t < 400)
      begin
        stalls++;
        t++;
        @(negedge clk);
        #1;
      end
      @(negedge clk);
    end
    rx_data_valid = 1'b0;
  endtask : send_rx
  task automatic seal();
    logic [7:0] s;
    s = 8'h00;
    for (int i = 3; i < exp.size(); i++) s = s + exp[i];
    exp.push_back(8'hFF - s);
  endtask : seal
  task automatic mk_rx(input int n, input logic [7:0] opt);
    logic [15:0] len;
    len = 16'h000B + 16'(n);
    exp = {8'h7E, len[15:8], len[7:0], 8'h80};
    for (int i = 7; i >= 0; i--) exp.push_back(rx_source_long[8*i+:8]);
    exp.push_back(rx_signal_dbm);
    exp.push_back(opt);
    for (int j = 0; j < n; j++) exp.push_back(8'h70 + j[7:0]);
    seal();
  endtask : mk_rx
  task automatic mk_status(input logic [7:0] id, input logic [7:0] ds);
    exp = {8'h7E, 8'h00, 8'h03, 8'h89, id, ds};
    seal();
  endtask : mk_status
  task automatic chk_frame();
    int t;
    t = 0;
    while (i_host.frames == nfr && t < 600)
    begin
      @(negedge clk);
      t++;
    end
    nfr = i_host.frames;
    `CHK(i_host.got.size(), exp.size())
    foreach (exp[i]) `CHK(i_host.got[i], exp[i])
    i_host.got.delete();
  endtask : chk_frame
  // Main sequence
  initial
  begin
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    `CHK(unescaped_mode, 1'b1)
    for (int i = 0; i < 10; i++)
    begin
      send_tx(8'(i + 1), codes[i], 1'b0);
      @(negedge clk);
      `CHK(busy, 1'b1)
      mk_status(8'(i + 1), codes[i]);
      chk_frame();
    end
    send_tx(8'hFF, 8'h2C, 1'b0);
    mk_status(8'hFF, 8'h31);
    chk_frame();
    send_tx(8'h52, 8'h01, 1'b1);
    mk_status(8'h52, 8'h00);
    chk_frame();
    send_tx(8'h00, 8'h02, 1'b0);
    repeat (30) @(negedge clk);
    `CHK(i_host.frames, nfr)
    `CHK(busy, 1'b0)
    $display("status frame tests done");
    for (int k = 1; k < 4; k++)
    begin
      slow = (k == 3);
      send_rx((k == 3) ? 20 : k + 1, k[0], k[1]);
      mk_rx((k == 3) ? 20 : k + 1, {5'h00, k[1], k[0], 1'b0});
      chk_frame();
    end
    `CHK(stalls > 0, 1'b1)
    slow = 1'b0;
    $display("receive frame tests done");
    api_output_format = 8'h01;
    send_rx(3, 1'b0, 1'b0);
    api_output_format = 8'h02;
    source_short_address = 16'h1234;
    send_rx(3, 1'b0, 1'b0);
    repeat (30) @(negedge clk);
    `CHK(drops, 2)
    `CHK(i_host.frames, nfr)
    api_escape_setting = 8'h00;
    repeat (2) @(negedge clk);
    `CHK(unescaped_mode, 1'b0)
    `CHK(i_host.bad_sum, 0)
    $display("drop and setting tests done");
    conclude();
  end
endmodule : tb_api_status_rx_framer
`default_nettype wire
